// File: common/prp_pkg.sv
`default_nettype none
package prp_pkg;

    // ==========================================================
    // memory geometry
    localparam int ROM_AW = 12;
    localparam int ROM_DW = 14;
    localparam logic [12:0] ROM_DEPTH = 13'h1000;
    localparam logic [12:0] LIB_MIN_WORDS = 13'h0200;
    localparam logic [12:0] LIB_STEP_WORDS = 13'h0080;
    localparam logic [3:0] LIB_SIZE_OFF = 4'h0;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;
    localparam logic [13:0] BLOCKED_WORD = 14'h0000;

    // ==========================================================
    // program counter vectoring
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam logic [3:0] IRQ_VEC_FIRST = 4'h1;
    localparam logic [3:0] IRQ_VEC_LAST = 4'hD;
    localparam int STACK_DEPTH = 8;

    // ==========================================================
    // writer register port
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam logic [3:0] REG_ADDR = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_CMD = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_CFG_LOW = 4'h4;
    localparam logic [3:0] REG_CFG_HIGH = 4'h5;

    localparam logic [2:0] CMD_READ = 3'h1;
    localparam logic [2:0] CMD_PROGRAM = 3'h2;
    localparam logic [2:0] CMD_ERASE_USER = 3'h3;
    localparam logic [2:0] CMD_ERASE_LIB = 3'h4;

    localparam int STAT_BUSY = 0;
    localparam int STAT_REFUSED = 1;
    localparam int STAT_FIVE_WIRE = 2;
    localparam int STAT_USER_PROT = 3;
    localparam int STAT_LIB_LOCK = 4;

    localparam logic [13:0] CFG_LOW_RESET = 14'h0000;
    localparam logic [13:0] CFG_HIGH_RESET = 14'h0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic libLock;
        logic [3:0] libSize;
        logic [8:0] reserved;
    } prp_cfg_low_t;

    typedef struct packed {
        logic userProt;
        logic extResetEn;
        logic [1:0] lowVoltMode;
        logic [1:0] watchdogMode;
        logic [7:0] reserved;
    } prp_cfg_high_t;

    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [3:0] addr;
        logic [15:0] wdata;
    } prp_bus_req_t;

    typedef struct packed {
        logic req;
        logic [11:0] addr;
    } prp_table_req_t;

    typedef struct packed {
        logic step;
        logic jump;
        logic [11:0] jumpAddr;
        logic irqTake;
        logic [3:0] irqSrc;
        logic retPop;
    } prp_pc_ctrl_t;

endpackage
`default_nettype wire

// File: hw/prp_pc_vector.sv
`timescale 1ns/1ps
`default_nettype none
module prp_pc_vector (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // sequencing requests
    input wire prp_pkg::prp_pc_ctrl_t ctrl,
    // program counter
    output logic [11:0] pc
);

    // ==========================================================
    // return stack, circular: a ninth push overwrites the oldest
    logic [11:0] stack_q [prp_pkg::STACK_DEPTH];
    logic [2:0] sp_q;
    logic [11:0] pc_q;
    logic irqValid;

    assign irqValid = ctrl.irqTake && (ctrl.irqSrc >= prp_pkg::IRQ_VEC_FIRST)
        && (ctrl.irqSrc <= prp_pkg::IRQ_VEC_LAST);

    // ==========================================================
    // program counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= prp_pkg::RESET_VECTOR; // see RQ9
        end else if (irqValid) begin
            pc_q <= {8'h00, ctrl.irqSrc}; // see RQ10
        end else if (ctrl.retPop) begin
            pc_q <= stack_q[sp_q - 3'h1];
        end else if (ctrl.jump) begin
            pc_q <= ctrl.jumpAddr;
        end else if (ctrl.step) begin
            pc_q <= pc_q + 12'h001;
        end
    end

    // ==========================================================
    // stack pointer and pushes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= 3'h0;
        end else if (irqValid) begin
            sp_q <= sp_q + 3'h1; // see RQ10
        end else if (ctrl.retPop) begin
            sp_q <= sp_q - 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (irqValid) begin
            stack_q[sp_q] <= pc_q; // see RQ10
        end
    end

    assign pc = pc_q;

endmodule
`default_nettype wire

// File: hw/prp_rom_access.sv
// Summary of operation
// RQ1: program store is 4K words of 14 bits plus a separate config word in an info area.
// RQ2: writer reads of program words succeed only while both protection bits are clear.
// RQ3: the config word can always be read, whatever the protection bits hold.
// RQ4: the user protection bit is cleared only by erasing the user code area; the code also clears it at reset.
// RQ5: the library lock bit is cleared only by erasing the library code area; the code also clears it at reset.
// RQ6: with the library lock set, writer programming of the user area still works.
// RQ7: with the library lock set, writer reads and writes of the library area are refused.
// RQ8: with user protection set, writer reads and updates of the user area are refused.
// RQ9: reset restarts the program counter at 000h and returns registers to defaults.
// RQ10: a taken interrupt pushes the program counter and jumps to its vector in 001h..00Dh.
// RQ11: library area size is 512 to 2304 words in 128-word steps.
// RQ12: programming works over a five-wire or an eight-wire connection alike.
// RQ13: the config word is writable only from the writer port, never by firmware.
// RQ14: bit 13 of the high config word is the user protection bit, one means protected.
// RQ15: library area size is coded in bits 12 to 9 of the low config word.
// RQ16: firmware table reads inside the library area never return stored contents; the code blocks them only while the library lock is set.
// RQ17: a blocked read returns a fixed constant and leaves memory untouched.
`timescale 1ns/1ps
`default_nettype none
module prp_rom_access #(
    parameter int AW = prp_pkg::ROM_AW,
    parameter int DW = prp_pkg::ROM_DW
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // writer register port
    input wire prp_pkg::prp_bus_req_t bus,
    output logic [prp_pkg::REG_DW-1:0] regRdata,
    // programming connection kind
    input wire logic fiveWireMode,
    // firmware table read
    input wire prp_pkg::prp_table_req_t table_read_low,
    output logic [DW-1:0] tableData,
    // instruction sequencing
    input wire prp_pkg::prp_pc_ctrl_t pcCtrl,
    output logic [AW-1:0] pc,
    output logic [DW-1:0] fetchWord
);

    // ==========================================================
    // storage
    logic [DW-1:0] multi_time_rom [2**AW]; // see RQ1
    prp_pkg::prp_cfg_low_t config_word_low_q; // see RQ1
    prp_pkg::prp_cfg_high_t config_word_high_q;

    typedef enum {PRP_IDLE, PRP_ERASE} prp_state_t;
    prp_state_t state_q;

    logic [AW-1:0] addr_q;
    logic [DW-1:0] dataIn_q;
    logic [DW-1:0] dataOut_q;
    logic refused_q;
    logic fiveWire_q;
    logic [AW:0] eraseAddr_q;
    logic [AW:0] eraseEnd_q;
    logic eraseLib_q;
    logic [prp_pkg::REG_DW-1:0] regRdata_q;
    logic [DW-1:0] tableData_q;
    logic [DW-1:0] fetchWord_q;
    logic [AW-1:0] pcNow;

    // ==========================================================
    // library area decode
    function automatic logic [12:0] libStart(input logic [3:0] code);
        logic [12:0] span;
        span = prp_pkg::LIB_MIN_WORDS + prp_pkg::LIB_STEP_WORDS * {9'h000, code - 4'h1};
        if (code == prp_pkg::LIB_SIZE_OFF) begin
            libStart = prp_pkg::ROM_DEPTH;
        end else begin
            libStart = prp_pkg::ROM_DEPTH - span; // see RQ11
        end
    endfunction

    function automatic logic inLib(input logic [11:0] a, input logic [3:0] code);
        inLib = {1'b0, a} >= libStart(code);
    endfunction

    // ==========================================================
    // command decode
    logic cmdWr;
    logic [2:0] cmdCode;
    logic idle;
    logic addrInLib;
    logic readOk;
    logic progOk;

    assign cmdWr = bus.wrStb && (bus.addr == prp_pkg::REG_CMD);
    assign cmdCode = bus.wdata[2:0];
    assign idle = (state_q == PRP_IDLE);
    assign addrInLib = inLib(addr_q, config_word_low_q.libSize);
    // any set bit hides every program word from the writer
    assign readOk = !config_word_high_q.userProt && !config_word_low_q.libLock; // see RQ2
    assign progOk = addrInLib ? !config_word_low_q.libLock // see RQ7
        : !config_word_high_q.userProt; // see RQ6 RQ8

    // ==========================================================
    // address and data holding registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            dataIn_q <= '0;
        end else if (bus.wrStb) begin
            if (bus.addr == prp_pkg::REG_ADDR) begin
                addr_q <= bus.wdata[AW-1:0];
            end
            if (bus.addr == prp_pkg::REG_DATA) begin
                dataIn_q <= bus.wdata[DW-1:0];
            end
        end
    end

    // ==========================================================
    // writer read result
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dataOut_q <= '0;
        end else if (cmdWr && idle && cmdCode == prp_pkg::CMD_READ) begin
            if (readOk && !(addrInLib && config_word_low_q.libLock)) begin
                dataOut_q <= multi_time_rom[addr_q];
            end else begin
                dataOut_q <= prp_pkg::BLOCKED_WORD; // see RQ17 RQ7 RQ8
            end
        end
    end

    // ==========================================================
    // refusal flag, updated by every command
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refused_q <= 1'b0;
        end else if (cmdWr) begin
            case (cmdCode)
                prp_pkg::CMD_READ: refused_q <= !idle || !readOk;
                prp_pkg::CMD_PROGRAM: refused_q <= !idle || !progOk;
                prp_pkg::CMD_ERASE_USER: refused_q <= !idle;
                prp_pkg::CMD_ERASE_LIB: refused_q <= !idle;
                default: refused_q <= 1'b1;
            endcase
        end
    end

    // ==========================================================
    // erase sequencer, one word per cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PRP_IDLE;
            eraseAddr_q <= '0;
            eraseEnd_q <= '0;
            eraseLib_q <= 1'b0;
        end else begin
            case (state_q)
                PRP_IDLE: begin
                    if (cmdWr && cmdCode == prp_pkg::CMD_ERASE_USER) begin
                        state_q <= PRP_ERASE;
                        eraseLib_q <= 1'b0;
                        eraseAddr_q <= '0;
                        eraseEnd_q <= libStart(config_word_low_q.libSize);
                    end else if (cmdWr && cmdCode == prp_pkg::CMD_ERASE_LIB) begin
                        state_q <= PRP_ERASE;
                        eraseLib_q <= 1'b1;
                        eraseAddr_q <= libStart(config_word_low_q.libSize);
                        eraseEnd_q <= prp_pkg::ROM_DEPTH;
                    end
                end
                PRP_ERASE: begin
                    if (eraseAddr_q >= eraseEnd_q) begin
                        state_q <= PRP_IDLE;
                    end else begin
                        eraseAddr_q <= eraseAddr_q + 13'h0001;
                    end
                end
                default: state_q <= PRP_IDLE;
            endcase
        end
    end

    // ==========================================================
    // memory write port, no reset: contents are nonvolatile
    always_ff @(posedge clk_sys) begin
        if (state_q == PRP_ERASE && eraseAddr_q < eraseEnd_q) begin
            multi_time_rom[eraseAddr_q[AW-1:0]] <= prp_pkg::ERASED_WORD;
        end else if (cmdWr && idle && cmdCode == prp_pkg::CMD_PROGRAM && progOk) begin
            multi_time_rom[addr_q] <= dataIn_q; // see RQ6
        end
    end

    // ==========================================================
    // config word: writer port only, firmware has no path here
    logic eraseDone;
    assign eraseDone = (state_q == PRP_ERASE) && (eraseAddr_q >= eraseEnd_q);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            config_word_low_q <= prp_pkg::CFG_LOW_RESET;
        end else if (eraseDone && eraseLib_q) begin
            config_word_low_q.libLock <= 1'b0; // see RQ5
        end else if (bus.wrStb && bus.addr == prp_pkg::REG_CFG_LOW && idle) begin
            // lock can only be raised here; size frozen while locked
            config_word_low_q.libLock <= config_word_low_q.libLock | bus.wdata[13]; // see RQ5 RQ13
            if (!config_word_low_q.libLock) begin
                config_word_low_q.libSize <= bus.wdata[12:9]; // see RQ15
            end
            config_word_low_q.reserved <= bus.wdata[8:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            config_word_high_q <= prp_pkg::CFG_HIGH_RESET;
        end else if (eraseDone && !eraseLib_q) begin
            config_word_high_q.userProt <= 1'b0; // see RQ4
        end else if (bus.wrStb && bus.addr == prp_pkg::REG_CFG_HIGH && idle) begin
            config_word_high_q.userProt <= config_word_high_q.userProt | bus.wdata[13]; // see RQ4 RQ14
            config_word_high_q.extResetEn <= bus.wdata[12];
            config_word_high_q.lowVoltMode <= bus.wdata[11:10];
            config_word_high_q.watchdogMode <= bus.wdata[9:8];
            config_word_high_q.reserved <= bus.wdata[7:0];
        end
    end

    // ==========================================================
    // connection kind seen by the writer logic
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fiveWire_q <= 1'b0;
        end else begin
            fiveWire_q <= fiveWireMode; // see RQ12
        end
    end

    // ==========================================================
    // register read-back, valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q <= '0;
        end else if (bus.rdStb) begin
            case (bus.addr)
                prp_pkg::REG_ADDR: regRdata_q <= {4'h0, addr_q};
                prp_pkg::REG_DATA: regRdata_q <= {2'h0, dataOut_q};
                prp_pkg::REG_STATUS: begin
                    regRdata_q <= '0;
                    regRdata_q[prp_pkg::STAT_BUSY] <= !idle;
                    regRdata_q[prp_pkg::STAT_REFUSED] <= refused_q;
                    regRdata_q[prp_pkg::STAT_FIVE_WIRE] <= fiveWire_q;
                    regRdata_q[prp_pkg::STAT_USER_PROT] <= config_word_high_q.userProt;
                    regRdata_q[prp_pkg::STAT_LIB_LOCK] <= config_word_low_q.libLock;
                end
                prp_pkg::REG_CFG_LOW: regRdata_q <= {2'h0, config_word_low_q}; // see RQ3
                prp_pkg::REG_CFG_HIGH: regRdata_q <= {2'h0, config_word_high_q}; // see RQ3
                default: regRdata_q <= '0;
            endcase
        end else begin
            regRdata_q <= '0;
        end
    end

    // ==========================================================
    // firmware table read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tableData_q <= '0;
        end else if (table_read_low.req) begin
            if (inLib(table_read_low.addr, config_word_low_q.libSize)
                && config_word_low_q.libLock) begin
                tableData_q <= prp_pkg::BLOCKED_WORD; // see RQ16
            end else begin
                tableData_q <= multi_time_rom[table_read_low.addr];
            end
        end
    end

    // ==========================================================
    // sequencing and instruction fetch
    prp_pc_vector u_pc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ctrl(pcCtrl),
        .pc(pcNow)
    );

    // fetch is not gated: library code must still execute
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetchWord_q <= '0;
        end else begin
            fetchWord_q <= multi_time_rom[pcNow];
        end
    end

    assign regRdata = regRdata_q;
    assign tableData = tableData_q;
    assign fetchWord = fetchWord_q;
    assign pc = pcNow;

endmodule
`default_nettype wire

// File: verif/prp_rom_access_checker.sv
`timescale 1ns/1ps
`default_nettype none
module prp_rom_access_checker #(
    parameter int AW = 12,
    parameter int DW = 14
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // observed ports
    input wire prp_pkg::prp_bus_req_t bus,
    input wire logic [15:0] regRdata,
    input wire logic fiveWireMode,
    input wire prp_pkg::prp_table_req_t table_read_low,
    input wire logic [DW-1:0] tableData,
    input wire prp_pkg::prp_pc_ctrl_t pcCtrl,
    input wire logic [AW-1:0] pc,
    input wire logic [DW-1:0] fetchWord
);
    // ====
    // one domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic irqOk = pcCtrl.irqTake && pcCtrl.irqSrc >= 4'h1 && pcCtrl.irqSrc <= 4'hD;
    wire logic others = pcCtrl.retPop || pcCtrl.jump || pcCtrl.step;

    chk_reset_state: assert property (
        $rose(rst_n) |-> pc == '0 && tableData == '0 && fetchWord == '0)
        else $error("state not cleared by reset");
    chk_irq_vector: assert property (
        irqOk |=> pc == {8'h00, $past(pcCtrl.irqSrc)})
        else $error("interrupt vector wrong");
    chk_irq_return: assert property (
        irqOk ##1 (pcCtrl.retPop && !pcCtrl.irqTake) |=> pc == $past(pc, 2))
        else $error("return address wrong");
    chk_irq_bad_src: assert property (
        pcCtrl.irqTake && !irqOk && !others |=> $stable(pc))
        else $error("invalid source moved pc");
    chk_step_wraps: assert property (
        pcCtrl.step && !pcCtrl.jump && !pcCtrl.retPop && !pcCtrl.irqTake
        |=> pc == $past(pc) + 12'h001)
        else $error("pc step wrong");
    chk_jump_target: assert property (
        pcCtrl.jump && !pcCtrl.retPop && !pcCtrl.irqTake |=> pc == $past(pcCtrl.jumpAddr))
        else $error("jump target wrong");
    chk_read_window: assert property (
        !$past(bus.rdStb) || $past(bus.addr) > 4'h5 |-> regRdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_table_hold: assert property (
        !table_read_low.req |=> $stable(tableData))
        else $error("table data changed without request");
    chk_wire_status: assert property (
        $stable(fiveWireMode)[*3] ##0 (bus.rdStb && bus.addr == prp_pkg::REG_STATUS)
        |=> regRdata[prp_pkg::STAT_FIVE_WIRE] == $past(fiveWireMode))
        else $error("connection kind not shown");
endmodule

bind prp_rom_access prp_rom_access_checker #(.AW(AW), .DW(DW)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .regRdata(regRdata),
    .fiveWireMode(fiveWireMode), .table_read_low(table_read_low),
    .tableData(tableData), .pcCtrl(pcCtrl), .pc(pc), .fetchWord(fetchWord));
`default_nettype wire

// File: verif/prp_rom_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
module prp_rom_access_tb;
    // ====
    // signals
    logic clk_sys;
    logic rst_n;
    prp_pkg::prp_bus_req_t bus;
    logic fiveWireMode;
    logic [15:0] regRdata;
    prp_pkg::prp_table_req_t tbl;
    logic [13:0] tableData;
    prp_pkg::prp_pc_ctrl_t pcCtrl;
    logic [11:0] pc;
    logic [13:0] fetchWord;
    logic [15:0] rv;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    prp_writer_model u_wr (.clk_sys(clk_sys), .bus(bus), .fiveWireMode(fiveWireMode),
        .regRdata(regRdata));
    prp_rom_access dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .regRdata(regRdata),
        .fiveWireMode(fiveWireMode), .table_read_low(tbl), .tableData(tableData),
        .pcCtrl(pcCtrl), .pc(pc), .fetchWord(fetchWord));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ====
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp,
        input string what);
        u_wr.regRead(a, rv);
        check(what, rv & m, exp);
    endtask

    task automatic prog(input logic [11:0] a, input logic [13:0] d);
        u_wr.regWrite(prp_pkg::REG_ADDR, {4'h0, a});
        u_wr.regWrite(prp_pkg::REG_DATA, {2'b00, d});
        u_wr.regWrite(prp_pkg::REG_CMD, {13'h0000, prp_pkg::CMD_PROGRAM});
    endtask

    task automatic fchk(input logic [11:0] a, input logic [13:0] exp, input string what);
        u_wr.regWrite(prp_pkg::REG_ADDR, {4'h0, a});
        u_wr.regWrite(prp_pkg::REG_CMD, {13'h0000, prp_pkg::CMD_READ});
        rdchk(prp_pkg::REG_DATA, 16'hFFFF, {2'b00, exp}, what);
    endtask

    // erase runs long: poll busy under a bound
    task automatic erase(input logic [2:0] c);
        u_wr.regWrite(prp_pkg::REG_CMD, {13'h0000, c});
        rv = 16'h0001;
        for (int i = 0; i < 6000 && rv[0] !== 1'b0; i++) u_wr.regRead(prp_pkg::REG_STATUS, rv);
        check("busy", rv & 16'h0001, 16'h0000);
    endtask

    task automatic tread(input logic [11:0] a, input logic [13:0] exp, input string what);
        tbl <= '{1'b1, a};
        @(posedge clk_sys);
        tbl <= '{1'b0, ~a};
        @(posedge clk_sys);
        check(what, {2'b00, tableData}, {2'b00, exp});
    endtask

    task automatic pcop(input prp_pkg::prp_pc_ctrl_t c, input logic [11:0] exp);
        pcCtrl <= c;
        @(posedge clk_sys);
        pcCtrl <= '0;
        @(posedge clk_sys);
        check("pc", {4'h0, pc}, {4'h0, exp});
    endtask

    // ====
    // scenarios
    task automatic t_pc();
        logic [11:0] base;
        check("pc reset", {4'h0, pc}, 16'h0000);
        pcop('{1'b0, 1'b1, 12'hFFF, 1'b0, 4'h0, 1'b0}, 12'hFFF);
        pcop('{1'b1, 1'b0, 12'h000, 1'b0, 4'h0, 1'b0}, 12'h000);
        for (int s = 0; s < 16; s++) begin
            base = pc;
            if (s >= 1 && s <= 13) begin
                // return follows the interrupt in the very next cycle
                pcCtrl <= '{1'b0, 1'b0, 12'h000, 1'b1, 4'(s), 1'b0};
                @(posedge clk_sys);
                pcCtrl <= '{1'b0, 1'b0, 12'h000, 1'b0, 4'h0, 1'b1};
                @(posedge clk_sys);
                check("pc irq", {4'h0, pc}, {12'h000, 4'(s)});
                pcop('0, base);
            end else begin
                pcop('{1'b0, 1'b0, 12'h000, 1'b1, 4'(s), 1'b0}, base);
            end
        end
        @(posedge clk_sys);
    endtask

    task automatic t_user();
        rdchk(prp_pkg::REG_STATUS, 16'hFFFF, 16'h0000, "status");
        rdchk(4'hF, 16'hFFFF, 16'h0000, "unmapped");
        erase(prp_pkg::CMD_ERASE_USER);
        prog(12'h00E, 14'h1A5C);
        prog(12'hFFF, 14'h2BC3);
        fchk(12'h00E, 14'h1A5C, "word");
        fchk(12'hFFF, 14'h2BC3, "top word");
        u_wr.regWrite(prp_pkg::REG_CFG_HIGH, 16'h2000);
        rdchk(prp_pkg::REG_CFG_HIGH, 16'hFFFF, 16'h2000, "cfg high");
        fchk(12'h00E, 14'h0000, "blocked");
        rdchk(prp_pkg::REG_STATUS, 16'hFFFF, 16'h000A, "status");
        prog(12'h00E, 14'h0123);
        u_wr.regWrite(prp_pkg::REG_CFG_HIGH, 16'h0000);
        rdchk(prp_pkg::REG_STATUS, 16'hFFFF, 16'h000A, "status");
        tread(12'h00E, 14'h1A5C, "unchanged");
        erase(prp_pkg::CMD_ERASE_USER);
        rdchk(prp_pkg::REG_STATUS, 16'h0008, 16'h0000, "prot clr");
        fchk(12'h00E, 14'h3FFF, "erased");
    endtask

    task automatic t_lib();
        prog(12'hE00, 14'h0C3A);
        prog(12'h010, 14'h1111);
        u_wr.regWrite(prp_pkg::REG_CFG_LOW, 16'h2200);
        rdchk(prp_pkg::REG_CFG_LOW, 16'hFFFF, 16'h2200, "cfg low");
        tread(12'hE00, 14'h0000, "lib table");
        tread(12'hDFF, 14'h3FFF, "edge table");
        prog(12'h010, 14'h2222);
        tread(12'h010, 14'h2222, "user update");
        rdchk(prp_pkg::REG_STATUS, 16'hFFFF, 16'h0010, "status");
        prog(12'hE00, 14'h0001);
        rdchk(prp_pkg::REG_STATUS, 16'hFFFF, 16'h0012, "status");
        fchk(12'hE00, 14'h0000, "lib read");
        fchk(12'h010, 14'h0000, "user read");
        u_wr.regWrite(prp_pkg::REG_CFG_LOW, 16'h0000);
        rdchk(prp_pkg::REG_STATUS, 16'h0010, 16'h0010, "lock kept");
        erase(prp_pkg::CMD_ERASE_LIB);
        rdchk(prp_pkg::REG_STATUS, 16'h0010, 16'h0000, "lock clr");
        fchk(12'h010, 14'h2222, "user kept");
        fchk(12'hE00, 14'h3FFF, "lib erased");
    endtask

    task automatic t_wires();
        u_wr.setFive(1'b1);
        @(posedge clk_sys);
        rdchk(prp_pkg::REG_STATUS, 16'h0004, 16'h0004, "five wire");
        prog(12'h020, 14'h3003);
        fchk(12'h020, 14'h3003, "five wire word");
        u_wr.setFive(1'b0);
        pcop('{1'b1, 1'b0, 12'h000, 1'b0, 4'h0, 1'b0}, pc + 12'h001);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check("pc again", {4'h0, pc}, 16'h0000);
        check("table again", {2'b00, tableData}, 16'h0000);
        @(posedge clk_sys);
        check("fetch", {2'b00, fetchWord}, {2'b00, prp_pkg::ERASED_WORD});
        u_wr.regWrite(prp_pkg::REG_CFG_LOW, 16'h3E00);
        tread(12'h700, 14'h0000, "max lib");
        tread(12'h6FF, 14'h3FFF, "below lib");
    endtask

    // ====
    // closing
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // erases dominate the run, a few thousand cycles for each user erase
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        rst_n = 1'b0;
        tbl = '0;
        pcCtrl = '0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_pc();
        t_user();
        t_lib();
        t_wires();
        final_report();
    end
endmodule
`default_nettype wire

// File: verif/prp_writer_model.sv
`timescale 1ns/1ps
`default_nettype none
module prp_writer_model (
    // clock
    input wire logic clk_sys,
    // register port toward the block
    output var prp_pkg::prp_bus_req_t bus,
    output var logic fiveWireMode,
    input wire logic [15:0] regRdata
);
    // ====
    // idle levels
    initial begin
        bus = '0;
        fiveWireMode = 1'b0;
    end

    // released lines show inverted data, so stale values never look valid
    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        bus <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge clk_sys);
    endtask

    task automatic regRead(input logic [3:0] a, output logic [15:0] d);
        bus <= '{1'b0, 1'b1, a, ~bus.wdata};
        @(posedge clk_sys);
        bus <= '{1'b0, 1'b0, ~a, bus.wdata};
        @(posedge clk_sys);
        // answer stands in the cycle after the strobe, taken at its closing edge
        d = regRdata;
    endtask

    // either connection kind drives the same register traffic
    task automatic setFive(input logic v);
        fiveWireMode <= v;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire
